// >>> hdl/pasd_top.sv
// module: auto-shutdown, restart and dead-band control of the bridge outputs
`timescale 1ns/1ps
module pasd_top (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // shutdown sources
  input  wire logic             cmp1_out,
  input  wire logic             cmp2_out,
  input  wire logic             fault_input_n,
  // pwm core side
  input  wire logic             pwm_enhanced,
  input  wire logic             pwm_half_bridge,
  input  wire logic             period_start,
  input  wire logic             pwm_a,
  input  wire logic             pwm_b,
  input  wire logic             pwm_c,
  input  wire logic             pwm_d,
  // bridge pins
  output logic                  bridge_out_a,
  output logic                  bridge_out_a_oe,
  output logic                  bridge_out_b,
  output logic                  bridge_out_b_oe,
  output logic                  bridge_out_c,
  output logic                  bridge_out_c_oe,
  output logic                  bridge_out_d,
  output logic                  bridge_out_d_oe,
  // interrupt
  output logic                  irq
);
  pasd_pkg::pasd_req_t   req;
  pasd_pkg::pasd_state_t state;
  pasd_pkg::pasd_state_t next_state;
  pasd_pkg::pasd_pin_t   pin_a;
  pasd_pkg::pasd_pin_t   pin_b;
  pasd_pkg::pasd_pin_t   pin_c;
  pasd_pkg::pasd_pin_t   pin_d;

  logic [7:0] shutdown_control;
  logic [7:0] deadband_restart_config;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [2:0] sync_1;
  logic [2:0] sync_2;
  logic       flag_prev;
  logic [7:0] next_control;
  logic       next_flag;
  logic [7:0] next_rdata;
  logic [1:0] next_irq_status;

  // source select decoding, used for the live condition and the readback
  function automatic logic src_hit(input logic [2:0] sel, input logic c1, input logic c2,
                                   input logic flt);
    logic hit;
    hit = 1'b0;
    if (sel == pasd_pkg::src_cmp1) begin
      hit = c1;
    end else if (sel == pasd_pkg::src_cmp2) begin
      hit = c2;
    end else if (sel == pasd_pkg::src_cmp_any) begin
      hit = c1 | c2;
    end else if (sel == pasd_pkg::src_fault) begin
      hit = flt;
    end else if (sel == pasd_pkg::src_fault_c2) begin
      hit = flt | c2;
    end else if (sel == pasd_pkg::src_fault_all) begin
      hit = flt | c1 | c2;
    end else begin
      hit = 1'b0; // disabled and the unlisted code 101
    end
    return hit;
  endfunction

  // safe-state decoding for one pin, shared by all four pins
  function automatic pasd_pkg::pasd_pin_t safe_pin(input logic [1:0] code);
    pasd_pkg::pasd_pin_t p;
    p.o  = (code == pasd_pkg::safe_high);
    p.oe = !code[1];
    return p;
  endfunction

  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;

  // two-flop synchronisers for the comparator and fault pin levels
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync_1 <= 3'h0;
      sync_2 <= 3'h0;
    end else begin
      sync_1 <= {!fault_input_n, cmp2_out, cmp1_out};
      sync_2 <= sync_1;
    end
  end

  // live shutdown condition; asynchronous path taps the pins directly
  wire [2:0] src_sel  = shutdown_control[pasd_pkg::src_hi:pasd_pkg::src_lo];
  wire       cond_raw = src_hit(src_sel, cmp1_out, cmp2_out, !fault_input_n);
  wire       cond     = src_hit(src_sel, sync_2[0], sync_2[1], sync_2[2]);
  wire       flag     = shutdown_control[pasd_pkg::flag_bit];
  wire       auto_rst = deadband_restart_config[pasd_pkg::restart_bit];
  wire [6:0] db_count = deadband_restart_config[pasd_pkg::count_hi:0];

  // register decode
  wire sel_ctl  = req.addr == pasd_pkg::addr_shutdown_control;
  wire sel_db   = req.addr == pasd_pkg::addr_deadband_config;
  wire sel_ist  = req.addr == pasd_pkg::addr_irq_status;
  wire sel_imsk = req.addr == pasd_pkg::addr_irq_mask;
  wire sel_live = req.addr == pasd_pkg::addr_live_status;
  wire wr_ctl   = req.wr && sel_ctl;
  wire wr_flag  = wr_ctl && !cond;

  // flag: set wins over any clear, software write, auto clear
  assign next_flag = cond ? 1'b1 :
                     wr_flag ? req.wdata[pasd_pkg::flag_bit] :
                     (auto_rst && flag) ? 1'b0 : flag;
  assign next_control = {next_flag, wr_ctl ? req.wdata[pasd_pkg::src_hi:0] : shutdown_control[pasd_pkg::src_hi:0]};

  // interrupt events: entry into shutdown, flag cleared; write one to clear
  wire ev_shut = next_flag && !flag;
  wire ev_rest = flag_prev && !flag;
  wire [1:0] ev = {ev_rest, ev_shut};
  wire [1:0] w1c = (req.wr && sel_ist) ? req.wdata[1:0] : 2'h0;
  assign next_irq_status = ev | (irq_status & ~w1c);

  // readback, data one cycle after the strobe, zero elsewhere
  assign next_rdata = !req.rd ? 8'h00 :
                      sel_ctl  ? shutdown_control :
                      sel_db   ? deadband_restart_config :
                      sel_ist  ? {6'h00, irq_status} :
                      sel_imsk ? {6'h00, irq_mask} :
                      sel_live ? {5'h00, state == pasd_pkg::pasd_run, cond, flag} : 8'h00;

  // register file
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      shutdown_control        <= pasd_pkg::shutdown_control_reset;
      deadband_restart_config <= pasd_pkg::deadband_config_reset;
      irq_status              <= pasd_pkg::irq_reset;
      irq_mask                <= pasd_pkg::irq_reset;
      flag_prev               <= 1'b0;
      reg_rdata               <= 8'h00;
      irq                     <= 1'b0;
    end else begin
      shutdown_control <= next_control;
      if (req.wr && sel_db) begin
        deadband_restart_config <= req.wdata;
      end
      if (req.wr && sel_imsk) begin
        irq_mask <= req.wdata[1:0];
      end
      irq_status <= next_irq_status;
      flag_prev  <= flag;
      reg_rdata  <= next_rdata;
      irq        <= |(next_irq_status & irq_mask);
    end
  end

  // period gate: safe while flag set, release only at a period start
  always_comb begin
    next_state = state;
    case (state)
      pasd_pkg::pasd_run: begin
        if (flag || cond) begin
          next_state = pasd_pkg::pasd_shutdown;
        end
      end
      pasd_pkg::pasd_shutdown: begin
        if (!flag && !cond) begin
          next_state = pasd_pkg::pasd_hold;
        end
      end
      pasd_pkg::pasd_hold: begin
        if (flag || cond) begin
          next_state = pasd_pkg::pasd_shutdown;
        end else if (period_start) begin
          next_state = pasd_pkg::pasd_run;
        end
      end
      default: begin
        next_state = pasd_pkg::pasd_shutdown;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= pasd_pkg::pasd_run;
    end else begin
      state <= next_state;
    end
  end

  // dead band on both half-bridge edges
  logic db_a;
  logic db_b;
  pasd_deadband u_db_a (
    .clk_sys        (clk_sys),
    .nrst           (nrst),
    .period_start   (period_start),
    .deadband_count (db_count),
    .raw_active     (pwm_a),
    .delayed_active (db_a)
  );
  pasd_deadband u_db_b (
    .clk_sys        (clk_sys),
    .nrst           (nrst),
    .period_start   (period_start),
    .deadband_count (db_count),
    .raw_active     (pwm_b),
    .delayed_active (db_b)
  );
  wire run_a = pwm_half_bridge ? db_a : pwm_a;
  wire run_b = pwm_half_bridge ? db_b : pwm_b;

  // registered normal drive of the four pins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_a <= '0;
      pin_b <= '0;
      pin_c <= '0;
      pin_d <= '0;
    end else begin
      pin_a <= '{o: run_a, oe: 1'b1};
      pin_b <= '{o: run_b, oe: 1'b1};
      pin_c <= '{o: pwm_c, oe: 1'b1};
      pin_d <= '{o: pwm_d, oe: 1'b1};
    end
  end

  // safe override is combinational so a fault reaches the pins at once;
  // the only outputs not straight from a flop, traded for no clock latency
  wire safe = pwm_enhanced && (cond_raw || state != pasd_pkg::pasd_run);
  wire [1:0] ac_code = shutdown_control[pasd_pkg::ac_hi:pasd_pkg::ac_lo];
  wire [1:0] bd_code = shutdown_control[pasd_pkg::bd_hi:pasd_pkg::bd_lo];
  pasd_pkg::pasd_pin_t safe_ac;
  pasd_pkg::pasd_pin_t safe_bd;
  assign safe_ac = safe_pin(ac_code);
  assign safe_bd = safe_pin(bd_code);
  assign bridge_out_a    = safe ? safe_ac.o  : pin_a.o;
  assign bridge_out_a_oe = safe ? safe_ac.oe : pin_a.oe;
  assign bridge_out_c    = safe ? safe_ac.o  : pin_c.o;
  assign bridge_out_c_oe = safe ? safe_ac.oe : pin_c.oe;
  assign bridge_out_b    = safe ? safe_bd.o  : pin_b.o;
  assign bridge_out_b_oe = safe ? safe_bd.oe : pin_b.oe;
  assign bridge_out_d    = safe ? safe_bd.o  : pin_d.o;
  assign bridge_out_d_oe = safe ? safe_bd.oe : pin_d.oe;
endmodule

// >>> hdl/pasd_pkg.sv
// package: register map, field layout and types for the pwm auto-shutdown block
package pasd_pkg;
  // register addresses on the plain register port
  localparam logic [3:0] addr_shutdown_control = 4'h0;
  localparam logic [3:0] addr_deadband_config  = 4'h1;
  localparam logic [3:0] addr_irq_status       = 4'h2;
  localparam logic [3:0] addr_irq_mask         = 4'h3;
  localparam logic [3:0] addr_live_status      = 4'h4;

  // shutdown control field positions
  localparam int unsigned flag_bit    = 7;
  localparam int unsigned src_hi      = 6;
  localparam int unsigned src_lo      = 4;
  localparam int unsigned ac_hi       = 3;
  localparam int unsigned ac_lo       = 2;
  localparam int unsigned bd_hi       = 1;
  localparam int unsigned bd_lo       = 0;
  // dead-band register field positions
  localparam int unsigned restart_bit = 7;
  localparam int unsigned count_hi    = 6;

  // reset values
  localparam logic [7:0] shutdown_control_reset = 8'h00;
  localparam logic [7:0] deadband_config_reset  = 8'h00;
  localparam logic [1:0] irq_reset              = 2'h0;

  // interrupt status bit positions
  localparam int unsigned irq_shutdown_bit = 0;
  localparam int unsigned irq_restart_bit  = 1;

  // source select codes
  localparam logic [2:0] src_disabled  = 3'h0;
  localparam logic [2:0] src_cmp1      = 3'h1;
  localparam logic [2:0] src_cmp2      = 3'h2;
  localparam logic [2:0] src_cmp_any   = 3'h3;
  localparam logic [2:0] src_fault     = 3'h4;
  localparam logic [2:0] src_fault_c2  = 3'h6;
  localparam logic [2:0] src_fault_all = 3'h7;

  // safe state codes (bit 1 set means high impedance)
  localparam logic [1:0] safe_low  = 2'h0;
  localparam logic [1:0] safe_high = 2'h1;

  localparam logic [6:0] count_zero = 7'h00;
  localparam logic [6:0] count_one  = 7'h01;

  // register-port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pasd_req_t;

  // one bridge pin as value and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } pasd_pin_t;

  // period states of the output gate
  typedef enum logic [1:0] {
    pasd_run      = 2'b00,
    pasd_shutdown = 2'b01,
    pasd_hold     = 2'b10
  } pasd_state_t;
endpackage

// >>> hdl/pasd_deadband.sv
// module: dead-band delay for one inactive-to-active output edge
`timescale 1ns/1ps
module pasd_deadband (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // control
  input  wire logic       period_start,
  input  wire logic [6:0] deadband_count,
  // signal
  input  wire logic       raw_active,
  output logic            delayed_active
);
  logic [6:0] cnt;
  logic       armed;
  logic       blocked;
  logic [6:0] next_cnt;
  logic       next_blocked;

  // count from the rising edge of the request; a fall restarts the wait
  assign next_cnt = !raw_active ? pasd_pkg::count_zero :
                    (cnt != deadband_count) ? cnt + pasd_pkg::count_one : cnt;
  // a delay longer than the pulse blocks the output for the rest of the cycle
  assign next_blocked = period_start ? 1'b0 :
                        (armed && !raw_active && cnt != deadband_count) ? 1'b1 : blocked;
  assign delayed_active = raw_active && !blocked && (cnt == deadband_count);

  // counter and blocking latch
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt     <= pasd_pkg::count_zero;
      armed   <= 1'b0;
      blocked <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      armed   <= raw_active;
      blocked <= next_blocked;
    end
  end
endmodule

// >>> testbench/pasd_props.sv
// checker: safe states, hold to period start, read port and dead band at the pins
`timescale 1ns/1ps
module pasd_props (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       nrst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // sources and pwm core
  input wire logic       cmp1_out,
  input wire logic       cmp2_out,
  input wire logic       fault_input_n,
  input wire logic       pwm_enhanced,
  input wire logic       pwm_half_bridge,
  input wire logic       period_start,
  input wire logic       pwm_a,
  input wire logic       pwm_c,
  // bridge pins
  input wire logic       bridge_out_a,
  input wire logic       bridge_out_a_oe,
  input wire logic       bridge_out_b,
  input wire logic       bridge_out_b_oe,
  input wire logic       bridge_out_c,
  input wire logic       bridge_out_c_oe,
  input wire logic       bridge_out_d,
  input wire logic       bridge_out_d_oe
);
  logic [6:0] ctl;
  logic [6:0] dbc;
  // shadows of control fields and dead-band count, taken from the writes
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctl <= 7'h00;
      dbc <= 7'h00;
    end else if (reg_wr && reg_addr == pasd_pkg::addr_shutdown_control) begin
      ctl <= reg_wdata[6:0];
    end else if (reg_wr && reg_addr == pasd_pkg::addr_deadband_config) begin
      dbc <= reg_wdata[6:0];
    end
  end
  // source decode, code 101 selects nothing
  wire logic [2:0] sel  = ctl[6:4];
  wire logic       cond = (sel[0] && (sel[1] || !sel[2]) && cmp1_out) || (sel[1] && cmp2_out)
                          || ((sel == 3'h4 || sel[2:1] == 2'h3) && !fault_input_n);
  wire logic ac_ok = ctl[3] ? (!bridge_out_a_oe && !bridge_out_c_oe)
                   : (bridge_out_a_oe && bridge_out_c_oe && bridge_out_a == ctl[2] && bridge_out_c == ctl[2]);
  wire logic bd_ok = ctl[1] ? (!bridge_out_b_oe && !bridge_out_d_oe)
                   : (bridge_out_b_oe && bridge_out_d_oe && bridge_out_b == ctl[0] && bridge_out_d == ctl[0]);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_safe_ac; pwm_enhanced && cond |-> ac_ok; endproperty
  a_safe_ac: assert property (p_safe_ac) else $error("pair ac not in safe state");
  property p_safe_bd; pwm_enhanced && cond |-> bd_ok; endproperty
  a_safe_bd: assert property (p_safe_bd) else $error("pair bd not in safe state");
  property p_hold;
    (cond && pwm_enhanced) [*4] ##1 (!cond && pwm_enhanced && !period_start) |-> ac_ok && bd_ok;
  endproperty
  a_hold: assert property (p_hold) else $error("outputs left safe state before period start");
  property p_normal;
    !pwm_enhanced && $past(!pwm_enhanced) && $past(nrst) |-> bridge_out_c == $past(pwm_c) && bridge_out_c_oe;
  endproperty
  a_normal: assert property (p_normal) else $error("pin c not following pwm drive");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  property p_unmapped; $past(reg_rd) && $past(reg_addr) > pasd_pkg::addr_live_status |-> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_db_delay;
    ($rose(pwm_a) && pwm_half_bridge && !pwm_enhanced && dbc == 7'h03) ##1 pwm_a [*4]
      |-> bridge_out_a && $past(bridge_out_a, 3) == 1'b0;
  endproperty
  a_db_delay: assert property (p_db_delay) else $error("dead band delay wrong");
  property p_db_long;
    ($rose(pwm_a) && pwm_half_bridge && !pwm_enhanced && dbc == 7'h03) ##1 (!pwm_a && !period_start) [*4]
      |-> !bridge_out_a;
  endproperty
  a_db_long: assert property (p_db_long) else $error("short pulse passed dead band");
endmodule
bind pasd_top pasd_props chk_u (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .cmp1_out, .cmp2_out, .fault_input_n, .pwm_enhanced, .pwm_half_bridge, .period_start, .pwm_a, .pwm_c,
  .bridge_out_a, .bridge_out_a_oe, .bridge_out_b, .bridge_out_b_oe, .bridge_out_c, .bridge_out_c_oe,
  .bridge_out_d, .bridge_out_d_oe);

// >>> testbench/pasd_bridge_model.sv
// bridge driver model: level seen at each gate driver input
`timescale 1ns/1ps
module pasd_bridge_model (
  // pin value and enable, pins a..d in bits 0..3
  input  wire logic [3:0] pin_o,
  input  wire logic [3:0] pin_oe,
  // gate driver input levels
  output logic      [3:0] gate_lvl
);
  // driver inputs carry pull-downs, so a released pin reads low
  assign gate_lvl = pin_o & pin_oe;
endmodule

// >>> testbench/pasd_top_test.sv
// testbench: register port, shutdown sources, safe states, restart and dead band
`timescale 1ns/1ps
module pasd_top_test;
  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       cmp1_out = 1'b0;
  logic       cmp2_out = 1'b0;
  logic       fault_input_n = 1'b1;
  logic       pwm_enhanced = 1'b1;
  logic       pwm_half_bridge = 1'b0;
  logic       period_start = 1'b0;
  logic [3:0] pwm = 4'h0;
  logic [3:0] pin_o;
  logic [3:0] pin_oe;
  logic [3:0] gate_lvl;
  logic       irq;
  logic [7:0] rd;
  int         error_cnt = 0;
  int         n_tests = 0;
  int         cyc = 0;
  // pwm and pins a..d in bits 0..3
  pasd_top dut_u (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp1_out(cmp1_out), .cmp2_out(cmp2_out),
    .fault_input_n(fault_input_n), .pwm_enhanced(pwm_enhanced), .pwm_half_bridge(pwm_half_bridge),
    .period_start(period_start), .pwm_a(pwm[0]), .pwm_b(pwm[1]), .pwm_c(pwm[2]), .pwm_d(pwm[3]),
    .bridge_out_a(pin_o[0]), .bridge_out_a_oe(pin_oe[0]), .bridge_out_b(pin_o[1]), .bridge_out_b_oe(pin_oe[1]),
    .bridge_out_c(pin_o[2]), .bridge_out_c_oe(pin_oe[2]), .bridge_out_d(pin_o[3]), .bridge_out_d_oe(pin_oe[3]),
    .irq(irq));
  pasd_bridge_model bridge_u (.pin_o(pin_o), .pin_oe(pin_oe), .gate_lvl(gate_lvl));
  always #25 clk_sys = ~clk_sys;
  // hang guard, the whole run needs well under this
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic pstart;
    @(posedge clk_sys);
    period_start <= 1'b1;
    @(posedge clk_sys);
    period_start <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // k: 0 comparator 1, 1 comparator 2, 2 fault pin
  task automatic trip(input int k, input logic on);
    @(posedge clk_sys);
    cmp1_out <= on && k == 0;
    cmp2_out <= on && k == 1;
    fault_input_n <= !(on && k == 2);
    #1;
  endtask
  // expected {oe, level} of pins d,c,b,a for safe codes
  function automatic logic [7:0] safe(input logic [1:0] ac, input logic [1:0] bd);
    logic x;
    logic y;
    x = ~ac[1];
    y = ~bd[1];
    return {y, x, y, x, y & bd[0], x & ac[0], y & bd[0], x & ac[0]};
  endfunction
  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      rdr(i[3:0]);
      chk(rd, 8'h00, "reset value");
    end
    rdr(pasd_pkg::addr_live_status);
    chk(rd, 8'h04, "live status");
    wr(4'hf, 8'hff);
    rdr(4'hf);
    chk(rd, 8'h00, "unmapped");
    rdr(pasd_pkg::addr_shutdown_control);
    chk(rd, 8'h00, "control after stray write");
    chk({7'h00, irq}, 8'h00, "irq at reset");
  endtask
  // every select code against every source, automatic restart on
  task automatic t_sources;
    logic [7:0] hit [3] = '{8'h8a, 8'hcc, 8'hd0};
    wr(pasd_pkg::addr_deadband_config, 8'h80);
    for (int s = 0; s < 8; s++) begin
      for (int k = 0; k < 3; k++) begin
        wr(pasd_pkg::addr_shutdown_control, {1'b0, s[2:0], 4'h5});
        trip(k, 1'b1);
        chk({pin_oe, gate_lvl}, hit[k][s] ? safe(2'h1, 2'h1) : 8'hf0, "source select");
        trip(k, 1'b0);
        repeat (6) @(posedge clk_sys);
        pstart;
        rdr(pasd_pkg::addr_shutdown_control);
        chk(rd, {1'b0, s[2:0], 4'h5}, "auto restart");
      end
    end
  endtask
  task automatic t_codes;
    for (int k = 0; k < 4; k++) begin
      pwm <= {4{~k[0]}};
      wr(pasd_pkg::addr_shutdown_control, {1'b0, 3'h1, k[1:0], 2'h3 - k[1:0]});
      trip(0, 1'b1);
      chk({pin_oe, gate_lvl}, safe(k[1:0], 2'h3 - k[1:0]), "safe codes");
      trip(0, 1'b0);
      repeat (6) @(posedge clk_sys);
      pstart;
      chk({pin_oe, gate_lvl}, {4'hf, {4{~k[0]}}}, "resume");
    end
  endtask
  task automatic t_soft;
    wr(pasd_pkg::addr_deadband_config, 8'h00);
    // earlier scenarios left events pending; start from a clean status
    wr(pasd_pkg::addr_irq_status, 8'h03);
    wr(pasd_pkg::addr_irq_mask, 8'h01);
    rdr(pasd_pkg::addr_irq_mask);
    chk(rd, 8'h01, "irq mask");
    wr(pasd_pkg::addr_shutdown_control, 8'h20);
    #1 chk({7'h00, irq}, 8'h00, "irq idle");
    pwm <= 4'hf;
    trip(1, 1'b1);
    repeat (5) @(posedge clk_sys);
    rdr(pasd_pkg::addr_shutdown_control);
    chk(rd, 8'ha0, "flag set");
    rdr(pasd_pkg::addr_live_status);
    chk(rd, 8'h03, "live in shutdown");
    chk({7'h00, irq}, 8'h01, "irq raised");
    wr(pasd_pkg::addr_shutdown_control, 8'h20);
    rdr(pasd_pkg::addr_shutdown_control);
    chk(rd, 8'ha0, "clear while active");
    pstart;
    chk({pin_oe, gate_lvl}, safe(2'h0, 2'h0), "period while flag");
    trip(1, 1'b0);
    repeat (5) @(posedge clk_sys);
    rdr(pasd_pkg::addr_shutdown_control);
    chk(rd, 8'ha0, "flag kept");
    wr(pasd_pkg::addr_shutdown_control, 8'h20);
    rdr(pasd_pkg::addr_shutdown_control);
    chk(rd, 8'h20, "software clear");
    chk({pin_oe, gate_lvl}, safe(2'h0, 2'h0), "mid period");
    pstart;
    chk({pin_oe, gate_lvl}, 8'hff, "resumed");
    rdr(pasd_pkg::addr_irq_status);
    chk(rd, 8'h03, "irq status");
    wr(pasd_pkg::addr_irq_status, 8'h03);
    rdr(pasd_pkg::addr_irq_status);
    chk(rd, 8'h00, "irq cleared");
    chk({7'h00, irq}, 8'h00, "irq low");
    wr(pasd_pkg::addr_irq_mask, 8'h00);
    wr(pasd_pkg::addr_shutdown_control, 8'h40);
    trip(2, 1'b1);
    repeat (5) @(posedge clk_sys);
    #1 chk({7'h00, irq}, 8'h00, "irq masked");
    trip(2, 1'b0);
    repeat (4) @(posedge clk_sys);
    wr(pasd_pkg::addr_shutdown_control, 8'h00);
    wr(pasd_pkg::addr_irq_status, 8'h03);
    pstart;
  endtask
  // half bridge with the override off, so only the dead band shapes pin a
  task automatic t_dead;
    pwm_enhanced <= 1'b0;
    pwm_half_bridge <= 1'b1;
    pwm <= 4'h0;
    wr(pasd_pkg::addr_deadband_config, 8'h03);
    rdr(pasd_pkg::addr_deadband_config);
    chk(rd, 8'h03, "dead band readback");
    pstart;
    pwm[0] <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk({7'h00, gate_lvl[0]}, 8'h00, "dead band low");
    repeat (4) @(posedge clk_sys);
    #1 chk({7'h00, gate_lvl[0]}, 8'h01, "dead band high");
    pwm[0] <= 1'b0;
    pstart;
    pwm[0] <= 1'b1;
    @(posedge clk_sys);
    pwm[0] <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 chk({7'h00, gate_lvl[0]}, 8'h00, "short pulse");
    wr(pasd_pkg::addr_deadband_config, 8'h00);
    pstart;
    pwm[0] <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk({7'h00, gate_lvl[0]}, 8'h01, "zero count");
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset;
    t_sources;
    t_codes;
    t_soft;
    t_dead;
    end_sim;
  end
endmodule
